// *** src/itq_pkg.sv ***
// Constants for the messaging register shell of the target image
package itq_pkg;
  // Image layout
  localparam logic [31:0] SHELL_SIZE = 32'h0000_1000;
  localparam logic [11:0] OFF_OPL_STATUS = 12'h030;
  localparam logic [11:0] OFF_OPL_MASK = 12'h034;
  localparam logic [11:0] OFF_INBOUND_Q = 12'h040;
  localparam logic [11:0] OFF_OUTBOUND_Q = 12'h044;
  localparam int BLOCK_SIZE_W = 4;
  localparam int SHELL_OFF_W = 12;
  // Field positions
  localparam int SERVICE_REQUEST_BIT = 3;
  localparam int MASK_BIT = 3;
  localparam int HOST_INDEX_LSB = 2;
  // Reset values
  localparam logic [31:0] HOST_INDEX_RESET = 32'h0000_0000;
  localparam logic MASK_RESET = 1'b0;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  // Value read from an empty queue
  localparam logic [31:0] EMPTY_QUEUE_WORD = 32'hffff_ffff;
  // Decoded target of an access
  typedef enum logic [2:0] {
    ITQ_TGT_NONE = 3'b000,
    ITQ_TGT_STATUS = 3'b001,
    ITQ_TGT_MASK = 3'b010,
    ITQ_TGT_INQ = 3'b011,
    ITQ_TGT_OUTQ = 3'b100,
    ITQ_TGT_HOSTIDX = 3'b101,
    ITQ_TGT_RSVD = 3'b110,
    ITQ_TGT_FRAME = 3'b111
  } itq_target_t;
endpackage : itq_pkg

// *** src/itq_shell.sv ***
// Messaging register shell of the target image with its queue ports
`timescale 1ns/1ns
module itq_shell
(
  // Clock and port reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Memory access into the image, offset from the image base
  input wire logic acc_valid_in,
  input wire logic acc_write_in,
  input wire logic [31:0] acc_addr_in,
  input wire logic [31:0] acc_wdata_in,
  output logic acc_ready_out,
  output logic ack_out,
  output logic claim_out,
  output logic [31:0] rdata_out,
  // Configuration
  input wire logic messaging_unit_enable_in,
  input wire logic ext_outbound_enable_in,
  input wire logic [11:0] host_outbound_index_offset_in,
  input wire logic [3:0] image_block_size_in,
  input wire logic [31:0] iop_outbound_index_in,
  // Inbound free list
  input wire logic ifl_valid_in,
  input wire logic [31:0] ifl_data_in,
  output logic ifl_pop_out,
  // Inbound post list
  output logic ipl_valid_out,
  output logic [31:0] ipl_data_out,
  input wire logic ipl_ready_in,
  // Outbound post list
  input wire logic opl_valid_in,
  input wire logic [31:0] opl_data_in,
  output logic opl_pop_out,
  // Outbound free list
  output logic ofl_valid_out,
  output logic [31:0] ofl_data_out,
  input wire logic ofl_ready_in,
  // Inbound frame storage
  output logic frame_valid_out,
  output logic frame_write_out,
  output logic [31:0] frame_addr_out,
  output logic [31:0] frame_wdata_out,
  input wire logic [31:0] frame_rdata_in,
  // Status
  output logic opl_irq_out,
  output logic [31:0] host_outbound_index_out
);

  logic take;
  itq_pkg::itq_target_t tgt;
  logic [31:0] image_limit;
  logic [11:0] shell_off;
  logic service_req;

  logic mask_q, mask_d;
  logic [31:0] hidx_q, hidx_d;
  logic ipl_valid_q, ipl_valid_d;
  logic [31:0] ipl_data_q, ipl_data_d;
  logic ofl_valid_q, ofl_valid_d;
  logic [31:0] ofl_data_q, ofl_data_d;
  logic ack_q, ack_d;
  logic claim_q, claim_d;
  logic [31:0] rdata_q, rdata_d;
  logic fvalid_q, fvalid_d;
  logic fwrite_q, fwrite_d;
  logic [31:0] faddr_q, faddr_d;
  logic [31:0] fwdata_q, fwdata_d;

  // A pending posted write holds off new accesses until it drains
  assign acc_ready_out = !ipl_valid_q && !ofl_valid_q;
  assign take = acc_valid_in && acc_ready_out;
  assign shell_off = acc_addr_in[itq_pkg::SHELL_OFF_W-1:0];
  assign image_limit = itq_pkg::SHELL_SIZE << image_block_size_in;

  // Address decode
  always_comb
  begin
    tgt = itq_pkg::ITQ_TGT_NONE;
    if (acc_addr_in >= image_limit)
    begin
      tgt = itq_pkg::ITQ_TGT_NONE;
    end
    else if (acc_addr_in >= itq_pkg::SHELL_SIZE)
    begin
      tgt = itq_pkg::ITQ_TGT_FRAME;
    end
    else if (!messaging_unit_enable_in)
    begin
      tgt = itq_pkg::ITQ_TGT_NONE;
    end
    else if (shell_off == itq_pkg::OFF_OPL_STATUS)
    begin
      tgt = itq_pkg::ITQ_TGT_STATUS;
    end
    else if (shell_off == itq_pkg::OFF_OPL_MASK)
    begin
      tgt = itq_pkg::ITQ_TGT_MASK;
    end
    else if (shell_off == itq_pkg::OFF_INBOUND_Q)
    begin
      tgt = itq_pkg::ITQ_TGT_INQ;
    end
    else if (shell_off == itq_pkg::OFF_OUTBOUND_Q)
    begin
      tgt = itq_pkg::ITQ_TGT_OUTQ;
    end
    else if (shell_off[11:2] == host_outbound_index_offset_in[11:2])
    begin
      tgt = itq_pkg::ITQ_TGT_HOSTIDX;
    end
    else
    begin
      tgt = itq_pkg::ITQ_TGT_RSVD;
    end
  end

  // Status ignores the mask by design
  assign service_req = opl_valid_in ||
    (ext_outbound_enable_in && (hidx_q != iop_outbound_index_in));
  assign opl_irq_out = messaging_unit_enable_in && service_req &&
    !mask_q;

  // Destructive reads pop in the cycle the access is taken
  assign ifl_pop_out = take && !acc_write_in &&
    (tgt == itq_pkg::ITQ_TGT_INQ) && ifl_valid_in;
  assign opl_pop_out = take && !acc_write_in &&
    (tgt == itq_pkg::ITQ_TGT_OUTQ) && opl_valid_in;

  always_comb
  begin
    mask_d = mask_q;
    hidx_d = hidx_q;
    ipl_valid_d = ipl_valid_q && !ipl_ready_in;
    ipl_data_d = ipl_data_q;
    ofl_valid_d = ofl_valid_q && !ofl_ready_in;
    ofl_data_d = ofl_data_q;
    ack_d = take;
    claim_d = take && (tgt != itq_pkg::ITQ_TGT_NONE);
    rdata_d = itq_pkg::DATA_RESET;
    fvalid_d = take && (tgt == itq_pkg::ITQ_TGT_FRAME);
    fwrite_d = acc_write_in;
    faddr_d = acc_addr_in;
    fwdata_d = acc_wdata_in;
    if (take)
    begin
      case (tgt)
        itq_pkg::ITQ_TGT_STATUS:
        begin
          rdata_d[itq_pkg::SERVICE_REQUEST_BIT] = service_req;
        end
        itq_pkg::ITQ_TGT_MASK:
        begin
          if (acc_write_in)
          begin
            mask_d = acc_wdata_in[itq_pkg::MASK_BIT];
          end
          rdata_d[itq_pkg::MASK_BIT] = mask_q;
        end
        itq_pkg::ITQ_TGT_INQ:
        begin
          if (acc_write_in)
          begin
            ipl_valid_d = 1'b1;
            ipl_data_d = acc_wdata_in;
          end
          else
          begin
            rdata_d = ifl_valid_in ? ifl_data_in
                                   : itq_pkg::EMPTY_QUEUE_WORD;
          end
        end
        itq_pkg::ITQ_TGT_OUTQ:
        begin
          if (acc_write_in)
          begin
            ofl_valid_d = 1'b1;
            ofl_data_d = acc_wdata_in;
          end
          else
          begin
            rdata_d = opl_valid_in ? opl_data_in
                                   : itq_pkg::EMPTY_QUEUE_WORD;
          end
        end
        itq_pkg::ITQ_TGT_HOSTIDX:
        begin
          if (acc_write_in)
          begin
            hidx_d = {acc_wdata_in[31:itq_pkg::HOST_INDEX_LSB], 2'b00};
          end
          rdata_d = hidx_q;
        end
        itq_pkg::ITQ_TGT_FRAME:
        begin
          rdata_d = frame_rdata_in;
        end
        default:
        begin
          rdata_d = itq_pkg::DATA_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      mask_q <= itq_pkg::MASK_RESET;
      hidx_q <= itq_pkg::HOST_INDEX_RESET;
      ipl_valid_q <= 1'b0;
      ipl_data_q <= itq_pkg::DATA_RESET;
      ofl_valid_q <= 1'b0;
      ofl_data_q <= itq_pkg::DATA_RESET;
      ack_q <= 1'b0;
      claim_q <= 1'b0;
      rdata_q <= itq_pkg::DATA_RESET;
      fvalid_q <= 1'b0;
      fwrite_q <= 1'b0;
      faddr_q <= itq_pkg::DATA_RESET;
      fwdata_q <= itq_pkg::DATA_RESET;
    end
    else
    begin
      mask_q <= mask_d;
      hidx_q <= hidx_d;
      ipl_valid_q <= ipl_valid_d;
      ipl_data_q <= ipl_data_d;
      ofl_valid_q <= ofl_valid_d;
      ofl_data_q <= ofl_data_d;
      ack_q <= ack_d;
      claim_q <= claim_d;
      rdata_q <= rdata_d;
      fvalid_q <= fvalid_d;
      fwrite_q <= fwrite_d;
      faddr_q <= faddr_d;
      fwdata_q <= fwdata_d;
    end
  end

  assign ack_out = ack_q;
  assign claim_out = claim_q;
  assign rdata_out = rdata_q;
  assign ipl_valid_out = ipl_valid_q;
  assign ipl_data_out = ipl_data_q;
  assign ofl_valid_out = ofl_valid_q;
  assign ofl_data_out = ofl_data_q;
  assign frame_valid_out = fvalid_q;
  assign frame_write_out = fwrite_q;
  assign frame_addr_out = faddr_q;
  assign frame_wdata_out = fwdata_q;
  assign host_outbound_index_out = hidx_q;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  chk_status_read: assert property (
    take && !acc_write_in && tgt == itq_pkg::ITQ_TGT_STATUS
    |=> rdata_out[itq_pkg::SERVICE_REQUEST_BIT] == $past(service_req)
        && claim_out)
    else $error("status read wrong");
  chk_mask_write: assert property (
    take && acc_write_in && tgt == itq_pkg::ITQ_TGT_MASK
    |=> mask_q == $past(acc_wdata_in[itq_pkg::MASK_BIT]))
    else $error("mask write lost");
  chk_disabled_hidden: assert property (
    take && !messaging_unit_enable_in
    && acc_addr_in < itq_pkg::SHELL_SIZE
    |=> !claim_out && rdata_out == 32'h0000_0000 && $stable(mask_q))
    else $error("shell visible while disabled");
  chk_irq_gate: assert property (
    opl_irq_out |-> service_req && !mask_q && messaging_unit_enable_in)
    else $error("irq without cause");
  chk_irq_fires: assert property (
    messaging_unit_enable_in && opl_valid_in && !mask_q |-> opl_irq_out)
    else $error("irq missing");
  chk_inq_pop: assert property (
    ifl_pop_out |=> ack_out && rdata_out == $past(ifl_data_in))
    else $error("pop data wrong");
  chk_inq_push: assert property (
    take && acc_write_in && tgt == itq_pkg::ITQ_TGT_INQ
    |=> ipl_valid_out && ipl_data_out == $past(acc_wdata_in) && ack_out)
    else $error("push missing");
  chk_posted_hold: assert property (
    ipl_valid_out && !ipl_ready_in
    |=> ipl_valid_out && $stable(ipl_data_out) && !acc_ready_out)
    else $error("posted write dropped");
  chk_index_status: assert property (
    ext_outbound_enable_in && hidx_q != iop_outbound_index_in
    |-> service_req)
    else $error("index mismatch not flagged");
  chk_frame_route: assert property (
    take && tgt == itq_pkg::ITQ_TGT_FRAME
    |=> frame_valid_out && frame_addr_out == $past(acc_addr_in)
        && $past(acc_addr_in) >= itq_pkg::SHELL_SIZE)
    else $error("frame access misrouted");
  chk_rsvd_zero: assert property (
    take && tgt == itq_pkg::ITQ_TGT_RSVD
    |=> rdata_out == 32'h0000_0000 && $stable(hidx_q))
    else $error("reserved space not zero");

  cov_inq_read: cover property (ifl_pop_out);
  cov_posted_stall: cover property (ipl_valid_out && !ipl_ready_in);
  cov_irq_masked: cover property (service_req && mask_q);
  cov_frame: cover property (frame_valid_out);

endmodule : itq_shell

// *** dv/itq_lists.sv ***
// Model of the queue storage that sits behind the shell
`timescale 1ns/1ns
module itq_lists
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Free list source
  input wire logic pop_in,
  output logic [31:0] head_out,
  // Post list sink, stalls on request
  input wire logic push_in,
  input wire logic [31:0] push_data_in,
  input wire logic stall_in,
  output logic ready_out
);
  int unsigned taken;
  logic [31:0] got[$];
  // Entries are 16-byte aligned frame offsets into the image
  assign head_out = 32'h0000_1000 + (taken << 4);
  assign ready_out = !stall_in;
  always @(posedge clk_in)
  begin
    if (rst_in)
      taken <= 0;
    else if (pop_in)
      taken <= taken + 1;
    if (!rst_in && push_in && ready_out)
      got.push_back(push_data_in);
  end
endmodule : itq_lists

// *** dv/testbench.sv ***
// Self-checking bench for the messaging register shell
`timescale 1ns/1ns
module testbench;
  logic clk, rst, vld, wr, rdy, ack, cl_o, en, opl_v, ipl_v, pop, prdy;
  logic stall, irq, cl, fv_o, fw_o, fv, fw, xen;
  logic [31:0] addr, wd, rd_o, head, ipl_d, frd, hidx, rd, x, m;
  logic [31:0] fa_o, fd_o, fa, fd, iop;
  logic [3:0] bs;
  int fail_count, n_checks, n;
  logic [31:0] exp_q[$];

  itq_shell dut (.mclk_in(clk), .rst_in(rst), .acc_valid_in(vld),
    .acc_write_in(wr), .acc_addr_in(addr), .acc_wdata_in(wd),
    .acc_ready_out(rdy), .ack_out(ack), .claim_out(cl_o),
    .rdata_out(rd_o), .messaging_unit_enable_in(en),
    .ext_outbound_enable_in(xen),
    .host_outbound_index_offset_in(12'h080),
    .image_block_size_in(bs), .iop_outbound_index_in(iop),
    .ifl_valid_in(1'b1), .ifl_data_in(head), .ifl_pop_out(pop),
    .ipl_valid_out(ipl_v), .ipl_data_out(ipl_d), .ipl_ready_in(prdy),
    .opl_valid_in(opl_v), .opl_data_in(x), .opl_pop_out(),
    .ofl_valid_out(), .ofl_data_out(), .ofl_ready_in(1'b1),
    .frame_valid_out(fv_o), .frame_write_out(fw_o), .frame_addr_out(fa_o),
    .frame_wdata_out(fd_o), .frame_rdata_in(frd), .opl_irq_out(irq),
    .host_outbound_index_out(hidx));

  itq_lists u_lists (.clk_in(clk), .rst_in(rst), .pop_in(pop),
    .head_out(head), .push_in(ipl_v), .push_data_in(ipl_d),
    .stall_in(stall), .ready_out(prdy));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Sink stalls at random each cycle, so a posted write always drains
  always @(negedge clk)
  begin
    if (rst)
      stall <= 1'b0;
    else
      stall <= rnd() > 32'h8000_0000;
  end

  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : rnd

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Request held from one falling edge until the taking rising edge
  task automatic acc(input logic w, input logic [31:0] a, d);
    int k;
    k = 0;
    wr = w;
    addr = a;
    wd = d;
    vld = 1'b1;
    while (rdy !== 1'b1)
    begin
      @(negedge clk);
      k++;
      if (k > 100)
      begin
        chk("ready", 32'h1, {31'h0, rdy});
        wrap_up();
      end
    end
    @(negedge clk);
    vld = 1'b0;
    rd = rd_o;
    cl = cl_o;
    fv = fv_o;
    fw = fw_o;
    fa = fa_o;
    fd = fd_o;
    chk("ack", 32'h1, {31'h0, ack});
    @(negedge clk);
  endtask : acc

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up();
  end

  initial
  begin
    x = 32'd94;
    {vld, wr, en, opl_v, xen} = '0;
    {addr, wd, frd, iop} = '0;
    bs = 4'h1;
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    en = 1'b1;
    acc(1'b0, 32'h30, 32'h0);
    chk("status rst", 32'h0, rd);
    acc(1'b0, 32'h34, 32'h0);
    chk("mask rst", 32'h0, rd);
    for (int i = 0; i < 4; i++)
    begin
      opl_v = i[0];
      m = {28'h0, i[1], 3'h0};
      acc(1'b1, 32'h34, (rnd() & 32'hffff_fff7) | m);
      acc(1'b0, 32'h34, 32'h0);
      chk("mask", m, rd);
      acc(1'b0, 32'h30, rnd());
      chk("status", {28'h0, i[0], 3'h0}, rd);
      chk("claim", 32'h1, {31'h0, cl});
      chk("irq", {31'h0, i[0] & !i[1]}, {31'h0, irq});
    end
    for (int k = 0; k < 3; k++)
    begin
      acc(1'b0, 32'h40, 32'h0);
      chk("free", 32'h0000_1000 + k * 16, rd);
    end
    for (int k = 0; k < 4; k++)
    begin
      exp_q.push_back(rnd());
      acc(1'b1, 32'h40, exp_q[k]);
    end
    n = 0;
    while (ipl_v !== 1'b0 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    chk("posted n", 32'd4, u_lists.got.size());
    foreach (exp_q[k])
      chk("posted", exp_q[k], u_lists.got[k]);
    m = rnd();
    acc(1'b1, 32'h80, m);
    acc(1'b0, 32'h80, 32'h0);
    chk("host idx", m & 32'hffff_fffc, rd);
    chk("host out", m & 32'hffff_fffc, hidx);
    opl_v = 1'b0;
    xen = 1'b1;
    iop = m & 32'hffff_fffc;
    acc(1'b0, 32'h30, 32'h0);
    chk("index same", 32'h0, rd);
    iop = ~m;
    acc(1'b0, 32'h30, 32'h0);
    chk("index differ", 32'h8, rd);
    xen = 1'b0;
    acc(1'b1, 32'h38, 32'hffff_ffff);
    acc(1'b0, 32'h38, 32'h0);
    chk("rsvd", 32'h0, rd);
    chk("rsvd claim", 32'h1, {31'h0, cl});
    frd = rnd();
    acc(1'b0, 32'h1000, 32'h0);
    chk("frame", frd, rd);
    chk("frame strobe", 32'h1, {31'h0, fv});
    chk("frame addr", 32'h0000_1000, fa);
    acc(1'b0, 32'h1ffc, 32'h0);
    chk("frame top", 32'h1, {31'h0, cl});
    acc(1'b0, 32'h2000, 32'h0);
    chk("beyond", 32'h0, {31'h0, cl});
    chk("beyond strobe", 32'h0, {31'h0, fv});
    acc(1'b1, 32'h1ff0, m);
    chk("frame wr", 32'h1, {31'h0, fv & fw});
    chk("frame wr addr", 32'h0000_1ff0, fa);
    chk("frame wdata", m, fd);
    en = 1'b0;
    acc(1'b1, 32'h34, 32'h0);
    acc(1'b0, 32'h34, 32'h0);
    chk("hidden", 32'h0, {31'h0, cl});
    chk("hidden data", 32'h0, rd);
    acc(1'b0, 32'h40, 32'h0);
    chk("hidden queue", 32'h0, rd);
    en = 1'b1;
    acc(1'b0, 32'h34, 32'h0);
    chk("mask kept", 32'h8, rd);
    acc(1'b0, 32'h40, 32'h0);
    chk("free kept", 32'h0000_1030, rd);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    acc(1'b0, 32'h34, 32'h0);
    chk("mask reset", 32'h0, rd);
    chk("index reset", 32'h0, hidx);
    wrap_up();
  end
endmodule : testbench
